// File: rtl/tce_pkg.sv
package tce_pkg;

    // avalon register map (byte addresses)
    localparam logic [7:0] TCE_A_CMD_LO   = 8'h00;
    localparam logic [7:0] TCE_A_CMD_HI   = 8'h04;
    localparam logic [7:0] TCE_A_CTRL     = 8'h08;
    localparam logic [7:0] TCE_A_STATUS   = 8'h0c;
    localparam logic [7:0] TCE_A_INFO     = 8'h10;
    localparam logic [7:0] TCE_A_BLKSIZE  = 8'h14;
    localparam logic [7:0] TCE_A_PARAM    = 8'h18;
    localparam logic [7:0] TCE_A_SEG0     = 8'h1c;
    localparam logic [7:0] TCE_A_SEG1     = 8'h20;
    localparam logic [7:0] TCE_A_SEG2     = 8'h24;

    // opcodes
    localparam logic [7:0] TCE_OP_WRITE   = 8'h0a;
    localparam logic [7:0] TCE_OP_FMARK   = 8'h10;
    localparam logic [7:0] TCE_OP_SPACE   = 8'h11;
    localparam logic [7:0] TCE_OP_MODESEL = 8'h15;
    localparam logic [7:0] TCE_OP_COPY    = 8'h18;

    // space codes
    localparam logic [1:0] TCE_SP_VBLK = 2'h0;
    localparam logic [1:0] TCE_SP_VFM  = 2'h1;
    localparam logic [1:0] TCE_SP_FBLK = 2'h2;
    localparam logic [1:0] TCE_SP_FFM  = 2'h3;

    // field positions
    localparam int TCE_B5_RETRY = 7;
    localparam int TCE_B5_ECC   = 6;
    localparam int TCE_B1_FIX   = 0;
    localparam int TCE_CTRL_GO  = 0;
    localparam int TCE_PRE_BYTES = 4;
    localparam int TCE_PAR_BYTES = 16;

    // block sizes and limits
    localparam logic [15:0] TCE_BLK_MIN  = 16'h0100;
    localparam logic [15:0] TCE_BLK_MAX  = 16'h2000;
    localparam logic [15:0] TCE_BLK_COPY = 16'h2000;
    localparam logic [15:0] TCE_ERASE_LEN = 16'h1000;
    localparam logic [2:0]  TCE_MAX_TRIES = 3'h7;

    typedef enum logic [2:0] {
        TCE_MV_NONE,
        TCE_MV_BLK_FWD,
        TCE_MV_BLK_REV,
        TCE_MV_FM_FWD,
        TCE_MV_FM_REV,
        TCE_MV_REPOS,
        TCE_MV_ERASE,
        TCE_MV_FMWRITE
    } tce_move_t;

    typedef struct packed {
        logic      go;
        tce_move_t op;
        logic [15:0] len;
    } tce_tape_req_t;

    typedef struct packed {
        logic done;
        logic fmark_hit;
        logic verify_err;
    } tce_tape_rsp_t;

endpackage

// File: rtl/tce_executor.sv
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
// How it works
// [R1] verify error: stop, reposition, erase 4096 bytes
// [R2] retry bit set: no write retry
// [R3] retry bit clear: rewrite past erased length
// [R4] seven failures: abort, valid flag, info count
// [R5] file mark: gap then mark pattern
// [R6] space code bits decode four types
// [R7] variable count signed; direction, zero no motion
// [R8] variable space: status after repositioning
// [R9] fixed space: sign picks direction, one item
// [R10] fixed space: status immediately on receipt
// [R11] file mark stops block spacing
// [R12] file mark stop: error, flags, info count
// [R13] block size 256 to 8192 from bytes 3-4
// [R14] block size resets to 8192
// [R15] copy always uses 8192 blocks
// [R16] copy takes 16-byte parameter list
// [R17] skip 4-byte preamble, keep 12 bytes
// [R18] copy byte 5: retry and ecc bits
// [R19] fixed writes use selected block size
// [R20] opcode decode; undefined opcode errors
// [R21] bad block size rejected, old kept
module tce_executor
    import tce_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    output tce_tape_req_t    tape_req_out,
    input  wire tce_tape_rsp_t tape_rsp_in,
    output logic             cmd_status_out,
    output logic             cmd_error_out
);

    typedef enum logic [2:0] {
        TCE_IDLE,
        TCE_PARAMS,
        TCE_MOVE,
        TCE_WAIT,
        TCE_DONE
    } tce_state_t;

    function automatic logic op_known(input logic [7:0] op);
        op_known = (op == TCE_OP_WRITE) || (op == TCE_OP_FMARK) || (op == TCE_OP_SPACE)
                || (op == TCE_OP_MODESEL) || (op == TCE_OP_COPY);
    endfunction

    // bus
    logic [31:0] rdata_q, rdata_d;
    logic        ack_q, ack_d;
    logic        wait_q, wait_d;
    logic [47:0] cmd_q, cmd_d;
    logic [15:0] blk_q, blk_d;
    logic [23:0] info_q, info_d;
    logic        vld_q, vld_d;
    logic        fil_q, fil_d;
    logic        err_q, err_d;
    logic        busy_q, busy_d;
    logic        stat_q, stat_d;
    logic [95:0] seg_q, seg_d;
    logic [4:0]  pcnt_q, pcnt_d;
    logic        retry_q, retry_d;
    logic        ecc_q, ecc_d;
    logic [15:0] wlen_q, wlen_d;
    // executor
    tce_state_t    st_q, st_d;
    tce_tape_req_t req_q, req_d;
    logic [23:0]   left_q, left_d;
    logic [23:0]   done_q, done_d;
    logic [2:0]    tries_q, tries_d;
    logic          is_fm_q, is_fm_d;
    logic          fixed_q, fixed_d;
    logic          fwd_q, fwd_d;
    logic          wr_q, wr_d;

    logic        bus_req;
    logic [7:0]  op;
    logic [1:0]  code;
    logic [23:0] cnt;
    logic [15:0] msel;
    logic        go;

    assign bus_req = (avs_read_in || avs_write_in) && !ack_q;
    assign op   = cmd_q[7:0];
    assign code = cmd_q[9:8];
    assign cnt  = {cmd_q[23:16], cmd_q[31:24], cmd_q[39:32]};
    assign msel = {cmd_q[31:24], cmd_q[39:32]};
    assign go   = bus_req && avs_write_in && (avs_address_in == TCE_A_CTRL)
               && avs_writedata_in[TCE_CTRL_GO] && !busy_q;

    always_comb
    begin
        rdata_d = rdata_q;
        ack_d   = bus_req;
        wait_d  = !bus_req;
        cmd_d   = cmd_q;
        blk_d   = blk_q;
        info_d  = info_q;
        vld_d   = vld_q;
        fil_d   = fil_q;
        err_d   = err_q;
        busy_d  = busy_q;
        stat_d  = 1'b0;
        seg_d   = seg_q;
        pcnt_d  = pcnt_q;
        retry_d = retry_q;
        ecc_d   = ecc_q;
        wlen_d  = wlen_q;
        st_d    = st_q;
        req_d   = req_q;
        req_d.go = 1'b0;
        left_d  = left_q;
        done_d  = done_q;
        tries_d = tries_q;
        is_fm_d = is_fm_q;
        fixed_d = fixed_q;
        fwd_d   = fwd_q;
        wr_d    = wr_q;
        // parameter bytes arrive while busy, command words must not
        if (bus_req && avs_write_in)
        begin
            case (avs_address_in)
                TCE_A_CMD_LO:
                begin
                    if (!busy_q)
                        cmd_d[31:0] = avs_writedata_in;
                end
                TCE_A_CMD_HI:
                begin
                    if (!busy_q)
                        cmd_d[47:32] = avs_writedata_in[15:0];
                end
                TCE_A_PARAM:
                begin
                    if (st_q == TCE_PARAMS)
                    begin
                        // only bytes past the preamble are kept  // see [R17]
                        if (pcnt_q >= 5'(TCE_PRE_BYTES))
                            seg_d = {seg_q[87:0], avs_writedata_in[7:0]};
                        pcnt_d = pcnt_q + 5'h1; // see [R16]
                    end
                end
                default: ;
            endcase
        end
        if (bus_req && avs_read_in)
        begin
            case (avs_address_in)
                TCE_A_CMD_LO:  rdata_d = cmd_q[31:0];
                TCE_A_CMD_HI:  rdata_d = {16'h0000, cmd_q[47:32]};
                TCE_A_STATUS:  rdata_d = {27'h0, ecc_q, fil_q, vld_q, err_q, busy_q};
                TCE_A_INFO:    rdata_d = {8'h00, info_q};
                TCE_A_BLKSIZE: rdata_d = {16'h0000, wlen_q};
                TCE_A_SEG0:    rdata_d = seg_q[95:64];
                TCE_A_SEG1:    rdata_d = seg_q[63:32];
                TCE_A_SEG2:    rdata_d = seg_q[31:0];
                default:       rdata_d = 32'h0000_0000;
            endcase
        end

        case (st_q)
            TCE_IDLE:
            begin
                if (go)
                begin
                    busy_d  = 1'b1;
                    err_d   = 1'b0;
                    vld_d   = 1'b0;
                    fil_d   = 1'b0;
                    done_d  = 24'h0;
                    tries_d = 3'h0;
                    retry_d = cmd_q[40 + TCE_B5_RETRY];
                    st_d    = TCE_DONE;
                    case (op) // see [R20]
                        TCE_OP_WRITE:
                        begin
                            wr_d   = 1'b1;
                            fixed_d = cmd_q[8 + TCE_B1_FIX];
                            wlen_d = fixed_d ? blk_q : cnt[15:0]; // see [R19]
                            left_d = fixed_d ? cnt : 24'h1;
                            st_d   = TCE_MOVE;
                        end
                        TCE_OP_FMARK:
                        begin
                            wr_d  = 1'b0;
                            // drive writes the gap before the mark  // see [R5]
                            req_d = '{go: 1'b1, op: TCE_MV_FMWRITE, len: 16'h0};
                            st_d  = TCE_WAIT;
                        end
                        TCE_OP_SPACE:
                        begin
                            wr_d    = 1'b0;
                            is_fm_d = code[0]; // see [R6]
                            fixed_d = code[1];
                            fwd_d   = !cnt[23]; // see [R7]
                            left_d  = code[1] ? 24'h1 : (cnt[23] ? 24'(-cnt) : cnt); // see [R9]
                            if (cnt == 24'h0)
                                st_d = TCE_DONE; // see [R7]
                            else
                                st_d = TCE_MOVE;
                            if (code[1])
                                stat_d = 1'b1; // see [R10]
                        end
                        TCE_OP_MODESEL:
                        begin
                            if (msel >= TCE_BLK_MIN && msel <= TCE_BLK_MAX) // see [R13]
                                blk_d = msel;
                            else
                                err_d = 1'b1; // see [R21]
                        end
                        TCE_OP_COPY:
                        begin
                            ecc_d  = cmd_q[40 + TCE_B5_ECC]; // see [R18]
                            wlen_d = TCE_BLK_COPY; // see [R15]
                            pcnt_d = 5'h0;
                            st_d   = TCE_PARAMS;
                        end
                        default: err_d = 1'b1; // see [R20]
                    endcase
                end
            end
            TCE_PARAMS:
            begin
                if (pcnt_q == 5'(TCE_PAR_BYTES))
                    st_d = TCE_DONE;
            end
            TCE_MOVE:
            begin
                req_d.go = 1'b1;
                if (wr_q)
                    req_d.op = TCE_MV_NONE;
                else if (is_fm_q)
                    req_d.op = fwd_q ? TCE_MV_FM_FWD : TCE_MV_FM_REV;
                else
                    req_d.op = fwd_q ? TCE_MV_BLK_FWD : TCE_MV_BLK_REV;
                req_d.len = wlen_q;
                st_d = TCE_WAIT;
            end
            TCE_WAIT:
            begin
                if (tape_rsp_in.done)
                begin
                    st_d = TCE_MOVE;
                    if (req_q.op == TCE_MV_FMWRITE)
                        st_d = TCE_DONE;
                    else if (req_q.op == TCE_MV_REPOS)
                    begin
                        req_d = '{go: 1'b1, op: TCE_MV_ERASE, len: TCE_ERASE_LEN}; // see [R1]
                        st_d  = TCE_WAIT;
                    end
                    else if (req_q.op == TCE_MV_ERASE)
                    begin
                        // erase always runs, so an aborted block leaves clean tape
                        if (retry_q || tries_q == TCE_MAX_TRIES) // see [R2] [R4]
                        begin
                            err_d  = 1'b1;
                            vld_d  = 1'b1;
                            info_d = left_q; // see [R4]
                            st_d   = TCE_DONE;
                        end
                        else
                            st_d = TCE_MOVE; // rewrite past erase  // see [R3]
                    end
                    else if (wr_q && tape_rsp_in.verify_err)
                    begin
                        tries_d = tries_q + 3'h1;
                        // stop and back up to block start  // see [R1]
                        req_d = '{go: 1'b1, op: TCE_MV_REPOS, len: wlen_q};
                        st_d  = TCE_WAIT;
                    end
                    else if (!wr_q && !is_fm_q && tape_rsp_in.fmark_hit)
                    begin
                        // drive halts on far side of the mark  // see [R11]
                        err_d  = 1'b1;
                        vld_d  = 1'b1;
                        fil_d  = 1'b1;
                        info_d = left_q; // mark block not counted  // see [R12]
                        st_d   = TCE_DONE;
                    end
                    else
                    begin
                        tries_d = 3'h0;
                        left_d  = left_q - 24'h1;
                        done_d  = done_q + 24'h1;
                        if (left_q == 24'h1)
                            st_d = TCE_DONE;
                    end
                end
            end
            TCE_DONE:
            begin
                busy_d = 1'b0;
                // fixed space already reported at receipt  // see [R8]
                if (!(op == TCE_OP_SPACE && fixed_q && !err_q))
                    stat_d = 1'b1;
                st_d = TCE_IDLE;
            end
            default: st_d = TCE_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rdata_q <= 32'h0000_0000;
            ack_q   <= 1'b0;
            wait_q  <= 1'b1;
            cmd_q   <= 48'h0;
            blk_q   <= TCE_BLK_MAX; // see [R14]
            info_q  <= 24'h0;
            vld_q   <= 1'b0;
            fil_q   <= 1'b0;
            err_q   <= 1'b0;
            busy_q  <= 1'b0;
            stat_q  <= 1'b0;
            seg_q   <= 96'h0;
            pcnt_q  <= 5'h0;
            retry_q <= 1'b0;
            ecc_q   <= 1'b0;
            wlen_q  <= TCE_BLK_MAX;
            st_q    <= TCE_IDLE;
            req_q   <= '{go: 1'b0, op: TCE_MV_NONE, len: 16'h0};
            left_q  <= 24'h0;
            done_q  <= 24'h0;
            tries_q <= 3'h0;
            is_fm_q <= 1'b0;
            fixed_q <= 1'b0;
            fwd_q   <= 1'b1;
            wr_q    <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            ack_q   <= ack_d;
            wait_q  <= wait_d;
            cmd_q   <= cmd_d;
            blk_q   <= blk_d;
            info_q  <= info_d;
            vld_q   <= vld_d;
            fil_q   <= fil_d;
            err_q   <= err_d;
            busy_q  <= busy_d;
            stat_q  <= stat_d;
            seg_q   <= seg_d;
            pcnt_q  <= pcnt_d;
            retry_q <= retry_d;
            ecc_q   <= ecc_d;
            wlen_q  <= wlen_d;
            st_q    <= st_d;
            req_q   <= req_d;
            left_q  <= left_d;
            done_q  <= done_d;
            tries_q <= tries_d;
            is_fm_q <= is_fm_d;
            fixed_q <= fixed_d;
            fwd_q   <= fwd_d;
            wr_q    <= wr_d;
        end
    end

    // waitrequest high until the registered answer is ready
    assign avs_waitrequest_out = wait_q;
    assign avs_readdata_out    = rdata_q;
    assign tape_req_out        = req_q;
    assign cmd_status_out      = stat_q;
    assign cmd_error_out       = err_q;

endmodule

// File: tb/tce_chk_sva.sv
`timescale 1ns/1ps
module tce_chk
    import tce_pkg::*;
(
    input wire logic          clk_in,
    input wire logic          rst_b_in,
    input wire logic [7:0]    avs_address_in,
    input wire logic          avs_read_in,
    input wire logic          avs_write_in,
    input wire logic [31:0]   avs_writedata_in,
    input wire logic          avs_waitrequest_out,
    input wire tce_tape_req_t tape_req_out,
    input wire tce_tape_rsp_t tape_rsp_in,
    input wire logic          cmd_status_out,
    input wire logic          cmd_error_out
);
    logic [31:0] cmd_q;
    logic [31:0] cmd_d;
    logic        out_q;
    logic        out_d;
    logic        ack;
    logic        sp;
    assign ack = avs_write_in && !avs_waitrequest_out;
    assign sp  = cmd_q[7:0] == TCE_OP_SPACE;
    // shadow of the last command word; host never rewrites it while busy
    always_comb
    begin
        cmd_d = cmd_q;
        out_d = tape_req_out.go || (out_q && !tape_rsp_in.done);
        if (ack && avs_address_in == TCE_A_CMD_LO)
            cmd_d = avs_writedata_in;
    end
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cmd_q <= 32'h00000000;
            out_q <= 1'b0;
        end
        else
        begin
            cmd_q <= cmd_d;
            out_q <= out_d;
        end
    end
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    wait_one_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    wait_cause_a: assert property (!avs_waitrequest_out |-> $past(avs_read_in || avs_write_in))
        else $error("acknowledge without request");
    stat_pulse_a: assert property (cmd_status_out |=> !cmd_status_out)
        else $error("status pulse too long");
    one_req_a: assert property (tape_req_out.go |-> !out_q)
        else $error("second tape request outstanding");
    erase_len_a: assert property (
        tape_req_out.go && tape_req_out.op == TCE_MV_ERASE |-> tape_req_out.len == TCE_ERASE_LEN)
        else $error("erase length wrong");
    space_op_a: assert property (
        tape_req_out.go && sp |-> tape_req_out.op == (cmd_q[8]
        ? (cmd_q[23] ? TCE_MV_FM_REV : TCE_MV_FM_FWD)
        : (cmd_q[23] ? TCE_MV_BLK_REV : TCE_MV_BLK_FWD)))
        else $error("space move wrong");
    fix_stat_a: assert property (
        ack && avs_address_in == TCE_A_CTRL && avs_writedata_in[TCE_CTRL_GO] && sp && cmd_q[9]
        |-> ##[0:2] cmd_status_out) else $error("fixed space status late");
    var_stat_a: assert property (
        cmd_status_out && sp && !cmd_q[9] |-> !out_q) else $error("status before motion end");
    fm_stop_a: assert property (
        tape_rsp_in.done && tape_rsp_in.fmark_hit && sp && cmd_q[9:8] == TCE_SP_VBLK
        |=> !tape_req_out.go throughout (##[0:5] cmd_status_out ##1 cmd_error_out))
        else $error("no stop on file mark");
    cover property (tape_rsp_in.done && tape_rsp_in.fmark_hit);
    cover property (tape_req_out.go && tape_req_out.op == TCE_MV_ERASE);
    cover property (cmd_status_out && cmd_error_out);
endmodule

bind tce_executor tce_chk u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_waitrequest_out(avs_waitrequest_out),
    .tape_req_out(tape_req_out), .tape_rsp_in(tape_rsp_in), .cmd_status_out(cmd_status_out),
    .cmd_error_out(cmd_error_out));

// File: tb/tce_tape_model.sv
`timescale 1ns/1ps
module tce_tape_model
    import tce_pkg::*;
(
    input  wire logic          clk_in,
    input  wire logic          rst_b_in,
    input  wire tce_tape_req_t req_in,
    input  wire logic          clr_in,
    input  wire logic [7:0]    dly_in,
    input  wire logic [7:0]    fm_at_in,
    input  wire logic [3:0]    verr_in,
    output tce_tape_rsp_t      rsp_out
);
    logic       pend_q, pend_d, tog_q;
    logic [7:0] cnt_q, cnt_d, n_q, n_d;
    tce_move_t  op_q, op_d;
    logic       fin, hit, bad;
    assign fin = pend_q && cnt_q == 8'h00;
    // file mark met on the fm_at-th block move; write fails verr times
    assign hit = op_q inside {TCE_MV_BLK_FWD, TCE_MV_BLK_REV} && n_q + 8'h01 == fm_at_in;
    assign bad = op_q == TCE_MV_NONE && n_q < {4'h0, verr_in};
    // qualifiers are junk outside done, so the executor must not peek early
    assign rsp_out = '{done: fin, fmark_hit: fin ? hit : tog_q, verify_err: fin ? bad : !tog_q};
    always_comb
    begin
        pend_d = pend_q;
        cnt_d  = cnt_q;
        op_d   = op_q;
        n_d    = clr_in ? 8'h00 : n_q;
        if (req_in.go)
        begin
            pend_d = 1'b1;
            cnt_d  = dly_in;
            op_d   = req_in.op;
        end
        else if (fin)
        begin
            pend_d = 1'b0;
            n_d    = n_q + {7'h00, op_q inside {TCE_MV_NONE, TCE_MV_BLK_FWD, TCE_MV_BLK_REV}};
        end
        else if (pend_q)
            cnt_d = cnt_q - 8'h01;
    end
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            {pend_q, tog_q, cnt_q, n_q} <= 18'h00000;
            op_q <= TCE_MV_NONE;
        end
        else
        begin
            {pend_q, tog_q, cnt_q, n_q} <= {pend_d, !tog_q, cnt_d, n_d};
            op_q <= op_d;
        end
    end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
    $display("mismatch at %0t: got %h exp %h", $time, (a), (b)); end end
module tb_top
    import tce_pkg::*;
;
    logic          clk_in, rst_b_in, rd, wr, wreq, stat, err, clr;
    logic [7:0]    addr, dly, fm_at;
    logic [3:0]    verr;
    logic [31:0]   wdata, rdo, got;
    tce_tape_req_t req;
    tce_tape_rsp_t rsp;
    int            mismatches, n_compared, cycles, n_stat, gos_at_stat;
    tce_move_t     ops[$];
    logic [15:0]   lens[$];
    tce_executor uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdo),
        .avs_waitrequest_out(wreq), .tape_req_out(req), .tape_rsp_in(rsp),
        .cmd_status_out(stat), .cmd_error_out(err));
    tce_tape_model u_tape (.clk_in(clk_in), .rst_b_in(rst_b_in), .req_in(req), .clr_in(clr),
        .dly_in(dly), .fm_at_in(fm_at), .verr_in(verr), .rsp_out(rsp));
    initial
    begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        cycles++;
        if (req.go)
        begin
            ops.push_back(req.op);
            lens.push_back(req.len);
        end
        if (stat)
        begin
            n_stat++;
            gos_at_stat = ops.size();
        end
        if (cycles == 50000)
        begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        {addr, wdata, wr, rd, clr} <= {a, d, w, !w, 1'b0};
        do
            @(posedge clk_in);
        while (wreq !== 1'b0);
        got = rdo;
        {wr, rd} <= 2'h0;
    endtask
    task automatic run(input logic [31:0] lo, input logic [31:0] hi);
        bus(1'b1, TCE_A_CMD_LO, lo);
        bus(1'b1, TCE_A_CMD_HI, hi);
        ops.delete();
        lens.delete();
        n_stat = 0;
        gos_at_stat = -1;
        clr <= 1'b1;
        bus(1'b1, TCE_A_CTRL, 32'h00000001);
    endtask
    task automatic idle();
        do
            bus(1'b0, TCE_A_STATUS, 32'h0);
        while (got[0] !== 1'b0);
    endtask
    task automatic t_mode();
        logic [15:0] sz[5] = '{16'h0100, 16'h00ff, 16'h2001, 16'h2000, 16'h0100};
        logic [15:0] cur;
        logic        e;
        run(32'h0000010a, 32'h00000001);
        idle();
        `CHK(lens[0], TCE_BLK_MAX)
        bus(1'b0, TCE_A_BLKSIZE, 32'h0);
        `CHK(got[15:0], TCE_BLK_MAX)
        cur = TCE_BLK_MAX;
        bus(1'b1, 8'hfc, 32'h5a5a5a5a);
        bus(1'b0, 8'hfc, 32'h0);
        `CHK(got, 32'h00000000)
        for (int i = 0; i < 5; i++)
        begin
            e = sz[i] < TCE_BLK_MIN || sz[i] > TCE_BLK_MAX;
            run({sz[i][15:8], 24'h000015}, {24'h000000, sz[i][7:0]});
            idle();
            `CHK(got[1], e)
            `CHK(n_stat, 1)
            cur = e ? cur : sz[i];
            run(32'h0000010a, 32'h00000001);
            idle();
            `CHK(lens[0], cur)
            bus(1'b0, TCE_A_BLKSIZE, 32'h0);
            `CHK(got[15:0], cur)
        end
        $display("test mode select done");
    endtask
    task automatic t_write();
        int w;
        for (int k = 0; k < 3; k++)
        begin
            verr <= (k == 1) ? 4'h7 : 4'h1;
            dly <= (k == 1) ? 8'h00 : 8'h14;
            run(32'h0000010a, {16'h0000, k == 2, 7'h00, 8'h02});
            idle();
            w = 0;
            foreach (ops[j])
                w += (ops[j] == TCE_MV_NONE);
            `CHK(w, k == 1 ? 7 : (k == 2 ? 1 : 3))
            `CHK(got[1], k != 0)
            `CHK(lens[0], 16'h0100)
            if (k == 0)
                `CHK({ops[1], ops[2]}, {TCE_MV_REPOS, TCE_MV_ERASE})
            else
            begin
                `CHK(got[2], 1'b1)
                bus(1'b0, TCE_A_INFO, 32'h0);
                `CHK(got[23:0], 24'h000002)
            end
        end
        verr <= 4'h0;
        $display("test write retry done");
    endtask
    task automatic t_space();
        logic [1:0]  cd;
        logic [23:0] c;
        int          n;
        logic [2:0]  mv;
        for (int i = 0; i < 10; i++)
        begin
            cd = (i < 8) ? 2'(i >> 1) : {i[0], 1'b0};
            n = (i >= 8) ? 0 : (cd[1] ? 1 : 3);
            c = 24'((i[0] && i < 8) ? -n : n);
            dly <= i[1] ? 8'h14 : 8'h00;
            run({c[15:8], c[23:16], 6'h00, cd, TCE_OP_SPACE}, {24'h000000, c[7:0]});
            idle();
            mv = cd[0] ? (c[23] ? TCE_MV_FM_REV : TCE_MV_FM_FWD)
                       : (c[23] ? TCE_MV_BLK_REV : TCE_MV_BLK_FWD);
            `CHK(ops.size(), n)
            if (n > 0)
                `CHK(ops[$], mv)
            `CHK(gos_at_stat, cd[1] ? 0 : n)
            `CHK(n_stat, 1)
            `CHK(got[1], 1'b0)
        end
        $display("test space done");
    endtask
    task automatic t_fmstop();
        logic [23:0] c;
        fm_at <= 8'h03;
        for (int i = 0; i < 2; i++)
        begin
            c = i ? 24'hfffffb : 24'h000005;
            run({c[15:8], c[23:16], 8'h00, TCE_OP_SPACE}, {24'h000000, c[7:0]});
            idle();
            `CHK(ops.size(), 3)
            `CHK(got[3:1], 3'h7)
            `CHK(err, 1'b1)
            bus(1'b0, TCE_A_INFO, 32'h0);
            `CHK(got[23:0], 24'h000003)
        end
        fm_at <= 8'h00;
        $display("test file mark stop done");
    endtask
    task automatic t_misc();
        run(32'h00000010, 32'h0);
        idle();
        `CHK(ops.size(), 1)
        `CHK(ops[0], TCE_MV_FMWRITE)
        run(32'h0000003f, 32'h0);
        idle();
        `CHK(got[1], 1'b1)
        `CHK(n_stat, 1)
        $display("test file mark and bad opcode done");
    endtask
    task automatic t_copy();
        logic [7:0] b;
        run(32'h00000018, 32'h0000c000);
        bus(1'b0, TCE_A_BLKSIZE, 32'h0);
        `CHK(got[15:0], TCE_BLK_COPY)
        for (int i = 0; i < 16; i++)
            bus(1'b1, TCE_A_PARAM, {24'h000000, 8'(8'h30 + i)});
        idle();
        `CHK(n_stat, 1)
        `CHK(got[4], 1'b1)
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b0, 8'(TCE_A_SEG0 + 4 * i), 32'h0);
            b = 8'(8'h34 + 4 * i);
            `CHK(got, {b, b + 8'h01, b + 8'h02, b + 8'h03})
        end
        $display("test copy done");
    endtask
    initial
    begin
        {rst_b_in, rd, wr, clr, addr, wdata} = '0;
        {dly, fm_at, verr} = '0;
        repeat (12) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_mode();
        t_write();
        t_space();
        t_fmstop();
        t_misc();
        t_copy();
        print_verdict();
    end
endmodule
